// *** shared/serial_rx_defs.vh ***
// serial_rx_defs.vh: register offsets, field positions and reset values
// for the asynchronous serial receiver; definitions only
`ifndef SERIAL_RX_DEFS_VH
`define SERIAL_RX_DEFS_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define OFS_FLAG 5'h00
`define OFS_DATA 5'h04
`define OFS_BAUD 5'h08
`define OFS_CTL1 5'h0c
`define OFS_CTL2 5'h10
`define OFS_RXFINE 5'h14
`define OFS_TXFINE 5'h18

// ----------------------------------------
// flag_port fields
// ----------------------------------------
`define FLG_FULL 5
`define FLG_IDLE 4
`define FLG_OVR 3
`define FLG_NOISE 2
`define FLG_FRAME 1
`define FLG_PAR 0

// ----------------------------------------
// control_port_one fields
// ----------------------------------------
`define C1_NINTH 7
`define C1_WORD9 4
`define C1_WAKE 3
`define C1_PARON 2
`define C1_PSENSE 1
`define C1_PIE 0

// ----------------------------------------
// control_port_two fields
// ----------------------------------------
`define C2_RXIE 5
`define C2_QIE 4
`define C2_RXON 2
`define C2_MUTE 1

// ----------------------------------------
// baud_divider_port fields and sampling
// ----------------------------------------
`define BD_PRE_HI 7
`define BD_PRE_LO 6
`define BD_TX_HI 5
`define BD_TX_LO 3
`define BD_RX_HI 2
`define BD_RX_LO 0
`define OVERSAMPLE 5'h10
`define RST_BYTE 8'h00

`endif

// *** src/serial_rx_tick.v ***
// serial_rx_tick.v: receive divider chain giving one 16x sample tick
// assumes settings static while the receiver is enabled
`include "serial_rx_defs.vh"
`default_nettype none

module serial_rx_tick (
  input wire clk,
  input wire rst,
  input wire run,
  input wire [1:0] preSel,
  input wire [2:0] rxSel,
  input wire [7:0] fineDiv,
  output reg tick
);
  // ----------------------------------------
  // prescale 1,3,4,13 then 2^n then fine 1..255
  // ----------------------------------------
  reg [3:0] preCnt_r;
  reg [6:0] pwrCnt_r;
  reg [7:0] fineCnt_r;
  reg [3:0] preMax;
  wire [6:0] pwrMax;
  wire preHit;
  wire pwrHit;
  wire fineHit;

  always @* begin
    case (preSel)
      2'h0: preMax = 4'h0;
      2'h1: preMax = 4'h2;
      2'h2: preMax = 4'h3;
      default: preMax = 4'hc;
    endcase
  end

  assign pwrMax = (7'h01 << rxSel) - 7'h01;
  assign preHit = (preCnt_r == preMax);
  assign pwrHit = preHit && (pwrCnt_r == pwrMax);
  // zero leaves the fine prescaler out of the chain
  assign fineHit = pwrHit && ((fineDiv == 8'h00) || (fineCnt_r == fineDiv - 8'h01));

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      preCnt_r <= 4'h0;
      pwrCnt_r <= 7'h00;
      fineCnt_r <= 8'h00;
      tick <= 1'b0;
    end else if (!run) begin
      preCnt_r <= 4'h0;
      pwrCnt_r <= 7'h00;
      fineCnt_r <= 8'h00;
      tick <= 1'b0;
    end else begin
      preCnt_r <= preHit ? 4'h0 : preCnt_r + 4'h1;
      if (preHit)
        pwrCnt_r <= pwrHit ? 7'h00 : pwrCnt_r + 7'h01;
      if (pwrHit)
        fineCnt_r <= fineHit ? 8'h00 : fineCnt_r + 8'h01;
      tick <= fineHit;
    end
  end
endmodule // serial_rx_tick

`default_nettype wire

// *** src/serial_rx.v ***
// serial_rx.v: receive half of an asynchronous NRZ serial port
// assumes a classic Wishbone master and serialInPin synchronous to clk
// Operation
// - bits shift in lsb first; words pass through rx_buffer
// - rx_on enables the receiver, which hunts for a start bit
// - complete word loads rx_buffer, sets full flag, irq if enabled
// - full flag clears only by flag read then data read
// - word while full sets overrun, buffer kept, irq if enabled
// - a break is handled as a framing fault
// - idle frame sets only the idle flag, no word loaded; idle irq if enabled
// - bit value is majority of samples 8,9,10; disagreement is noise
// - noise flag rises with full flag, data kept, no own irq
// - noise flag clears by flag read then data read
// - start bit voting one discards frame, noise shown with next word
// - missing stop bit sets framing flag, data still transferred
// - rate is clk over 16 times prescale times power of two
// - nonzero fine prescaler divides further by 1 to 255
// - mute blocks every receive flag and interrupt
// - idle wake clears mute without setting idle flag
// - address wake on data msb one clears mute, word received
// - frame is start, 8 or 9 bits with optional parity, stop
// - parity even for sense 0, odd for sense 1
// - parity failure sets parity flag, irq if enabled
// - in 9-bit mode the msb goes to ninth_rx_bit
`include "serial_rx_defs.vh"
`default_nettype none

module serial_rx (
  input wire clk,
  input wire rst,
  input wire serialInPin,
  input wire cpuMask,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [4:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg wb_err_o,
  output reg irq
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam IDLE = 2'h0;
  localparam START = 2'h1;
  localparam DATA = 2'h2;
  localparam STOP = 2'h3;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] baudDividerPort_r;
  reg [7:0] rxFinePrescaler_r;
  reg [7:0] txFinePrescaler_r;
  reg word9_r;
  reg wake_r;
  reg parityOn_r;
  reg paritySense_r;
  reg parityIrqEn_r;
  reg ninthRxBit_r;
  reg rxIrqEn_r;
  reg quietIrqEn_r;
  reg rxOn_r;
  reg muteFlag_r;
  reg [7:0] rxBuffer_r;
  reg rxFullFlag_r;
  reg idleFlag_r;
  reg ovrFlag_r;
  reg noiseFlag_r;
  reg framingFlag_r;
  reg parityFailFlag_r;
  reg flagSeen_r;
  reg hiddenNoise_r;
  reg [1:0] state_r;
  reg [3:0] smp_r;
  reg [3:0] bitIdx_r;
  reg [8:0] shift_r;
  reg [2:0] votes_r;
  reg frameNoise_r;
  reg allOnes_r;
  reg [2:0] hist_r;
  reg [7:0] idleCnt_r;
  wire tick;

  serial_rx_tick divider (
    .clk(clk),
    .rst(rst),
    .run(rxOn_r),
    .preSel(baudDividerPort_r[`BD_PRE_HI:`BD_PRE_LO]),
    .rxSel(baudDividerPort_r[`BD_RX_HI:`BD_RX_LO]),
    .fineDiv(rxFinePrescaler_r),
    .tick(tick)
  );

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire [4:0] adr = {wb_adr_i[4:2], 2'b00};
  wire hit = (adr == `OFS_FLAG) || (adr == `OFS_DATA) || (adr == `OFS_BAUD) ||
             (adr == `OFS_CTL1) || (adr == `OFS_CTL2) || (adr == `OFS_RXFINE) ||
             (adr == `OFS_TXFINE);
  wire wr = req && hit && wb_we_i && wb_sel_i[0];
  wire rdFlag = req && hit && !wb_we_i && (adr == `OFS_FLAG);
  wire rdData = req && hit && !wb_we_i && (adr == `OFS_DATA);
  wire clrSeq = rdData && flagSeen_r;
  wire [7:0] flagByte = {2'b00, rxFullFlag_r, idleFlag_r, ovrFlag_r, noiseFlag_r,
                         framingFlag_r, parityFailFlag_r};
  wire [7:0] ctl1Byte = {ninthRxBit_r, 2'b00, word9_r, wake_r, parityOn_r,
                         paritySense_r, parityIrqEn_r};
  wire [7:0] ctl2Byte = {2'b00, rxIrqEn_r, quietIrqEn_r, 1'b0, rxOn_r, muteFlag_r, 1'b0};
  reg [7:0] rdByte;

  always @* begin
    case (adr)
      `OFS_FLAG: rdByte = flagByte;
      `OFS_DATA: rdByte = rxBuffer_r;
      `OFS_BAUD: rdByte = baudDividerPort_r;
      `OFS_CTL1: rdByte = ctl1Byte;
      `OFS_CTL2: rdByte = ctl2Byte;
      `OFS_RXFINE: rdByte = rxFinePrescaler_r;
      `OFS_TXFINE: rdByte = txFinePrescaler_r;
      default: rdByte = `RST_BYTE;
    endcase
  end

  // ----------------------------------------
  // sampling and frame decode
  // ----------------------------------------
  wire [3:0] dataLen = word9_r ? 4'h9 : 4'h8;
  wire [2:0] v3 = {votes_r[1:0], serialInPin};
  wire voteBit = (v3[0] & v3[1]) | (v3[0] & v3[2]) | (v3[1] & v3[2]);
  wire voteNoisy = !(v3 == 3'b000 || v3 == 3'b111);
  wire atLast = (smp_r == 4'h9);
  wire [8:0] word = shift_r;
  wire [8:0] wordAligned = word9_r ? word : {1'b0, word[8:1]};
  wire msb = word9_r ? wordAligned[8] : wordAligned[7];
  wire parOdd = word9_r ? ^wordAligned[8:0] : ^wordAligned[7:0];
  wire parBad = parityOn_r && (parOdd != paritySense_r);
  wire dataMsb = word9_r ? (parityOn_r ? wordAligned[7] : wordAligned[8])
                         : (parityOn_r ? wordAligned[6] : wordAligned[7]);
  // frame end events, valid at the stop bit's sample 10
  wire stopDone = (state_r == STOP) && tick && atLast;
  // idle: one whole frame of ones counted after a frame has ended
  wire [7:0] frameTicks = {dataLen + 4'h2, 4'h0};
  wire startEdge = hist_r[0] && !serialInPin;
  wire isIdle = (state_r == IDLE) && tick && allOnes_r && serialInPin &&
                (idleCnt_r == frameTicks - 8'h01);
  wire isWord = stopDone;
  wire addrWake = muteFlag_r && wake_r && dataMsb;
  wire accept = isWord && (!muteFlag_r || addrWake);
  wire idleWake = isIdle && muteFlag_r && !wake_r;
  wire idleSet = isIdle && !muteFlag_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= IDLE;
      smp_r <= 4'h0;
      bitIdx_r <= 4'h0;
      shift_r <= 9'h000;
      votes_r <= 3'h0;
      frameNoise_r <= 1'b0;
      allOnes_r <= 1'b0;
      hist_r <= 3'h7;
      idleCnt_r <= 8'h00;
    end else if (!rxOn_r) begin
      state_r <= IDLE;
      hist_r <= 3'h7;
      allOnes_r <= 1'b0;
    end else if (tick) begin
      hist_r <= {hist_r[1:0], serialInPin};
      votes_r <= v3;
      case (state_r)
        IDLE: begin
          if (startEdge) begin
            state_r <= START;
            smp_r <= 4'h1;
            frameNoise_r <= (hist_r != 3'b111);
            allOnes_r <= 1'b0;
          end else if (!serialInPin) begin
            idleCnt_r <= 8'h00;
          end else if (allOnes_r) begin
            idleCnt_r <= idleCnt_r + 8'h01;
            if (isIdle)
              allOnes_r <= 1'b0;
          end
        end
        START: begin
          smp_r <= smp_r + 4'h1;
          if (atLast) begin
            if (voteBit) begin
              state_r <= IDLE;
              smp_r <= 4'h0;
            end else begin
              frameNoise_r <= frameNoise_r | voteNoisy;
            end
          end
          if (smp_r == 4'hf) begin
            state_r <= DATA;
            smp_r <= 4'h0;
            bitIdx_r <= 4'h0;
          end
        end
        DATA: begin
          smp_r <= smp_r + 4'h1;
          if (atLast) begin
            shift_r <= {voteBit, shift_r[8:1]};
            frameNoise_r <= frameNoise_r | voteNoisy;
          end
          if (smp_r == 4'hf) begin
            smp_r <= 4'h0;
            bitIdx_r <= bitIdx_r + 4'h1;
            if (bitIdx_r == dataLen - 4'h1)
              state_r <= STOP;
          end
        end
        STOP: begin
          smp_r <= smp_r + 4'h1;
          if (atLast) begin
            state_r <= IDLE;
            smp_r <= 4'h0;
            allOnes_r <= 1'b1;
            idleCnt_r <= 8'h00;
          end
        end
        default: state_r <= IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // flags, buffer and bus registers
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      baudDividerPort_r <= `RST_BYTE;
      rxFinePrescaler_r <= `RST_BYTE;
      txFinePrescaler_r <= `RST_BYTE;
      word9_r <= 1'b0;
      wake_r <= 1'b0;
      parityOn_r <= 1'b0;
      paritySense_r <= 1'b0;
      parityIrqEn_r <= 1'b0;
      ninthRxBit_r <= 1'b0;
      rxIrqEn_r <= 1'b0;
      quietIrqEn_r <= 1'b0;
      rxOn_r <= 1'b0;
      muteFlag_r <= 1'b0;
      rxBuffer_r <= `RST_BYTE;
      rxFullFlag_r <= 1'b0;
      idleFlag_r <= 1'b0;
      ovrFlag_r <= 1'b0;
      noiseFlag_r <= 1'b0;
      framingFlag_r <= 1'b0;
      parityFailFlag_r <= 1'b0;
      flagSeen_r <= 1'b0;
      hiddenNoise_r <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      wb_ack_o <= req && hit;
      wb_err_o <= req && !hit;
      wb_dat_o <= req ? {24'h000000, rdByte} : 32'h00000000;
      if (rdFlag)
        flagSeen_r <= 1'b1;
      else if (req && hit)
        flagSeen_r <= 1'b0;
      if (wr) begin
        case (adr)
          `OFS_BAUD: baudDividerPort_r <= wb_dat_i[7:0];
          `OFS_RXFINE: rxFinePrescaler_r <= wb_dat_i[7:0];
          `OFS_TXFINE: txFinePrescaler_r <= wb_dat_i[7:0];
          `OFS_CTL1: begin
            word9_r <= wb_dat_i[`C1_WORD9];
            wake_r <= wb_dat_i[`C1_WAKE];
            parityOn_r <= wb_dat_i[`C1_PARON];
            paritySense_r <= wb_dat_i[`C1_PSENSE];
            parityIrqEn_r <= wb_dat_i[`C1_PIE];
          end
          `OFS_CTL2: begin
            rxIrqEn_r <= wb_dat_i[`C2_RXIE];
            quietIrqEn_r <= wb_dat_i[`C2_QIE];
            rxOn_r <= wb_dat_i[`C2_RXON];
            muteFlag_r <= wb_dat_i[`C2_MUTE];
          end
          default: ;
        endcase
      end
      // clears first; hardware sets below win in the same cycle
      if (clrSeq) begin
        rxFullFlag_r <= 1'b0;
        idleFlag_r <= 1'b0;
        ovrFlag_r <= 1'b0;
        noiseFlag_r <= 1'b0;
        framingFlag_r <= 1'b0;
        parityFailFlag_r <= 1'b0;
      end
      if (state_r == START && tick && atLast && voteBit)
        hiddenNoise_r <= 1'b1;
      if (addrWake && isWord)
        muteFlag_r <= 1'b0;
      if (idleWake)
        muteFlag_r <= 1'b0;
      if (idleSet)
        idleFlag_r <= 1'b1;
      if (accept) begin
        if (rxFullFlag_r && !clrSeq) begin
          ovrFlag_r <= 1'b1;
        end else begin
          rxBuffer_r <= wordAligned[7:0];
          ninthRxBit_r <= word9_r ? wordAligned[8] : ninthRxBit_r;
          rxFullFlag_r <= 1'b1;
          noiseFlag_r <= frameNoise_r | voteNoisy | hiddenNoise_r;
          framingFlag_r <= !voteBit;
          parityFailFlag_r <= parBad;
          hiddenNoise_r <= 1'b0;
        end
      end
      irq <= !cpuMask && !muteFlag_r &&
             ((rxIrqEn_r && (rxFullFlag_r || ovrFlag_r)) ||
              (quietIrqEn_r && idleFlag_r) ||
              (parityIrqEn_r && parityFailFlag_r));
    end
  end
endmodule // serial_rx

`default_nettype wire

// *** bench/serial_rx_props.sv ***
// serial_rx_props.sv: port-level assertions for serial_rx
// assumes a classic Wishbone master and the one-cycle answer of serial_rx
`default_nettype none
module serial_rx_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic serialInPin,
  input wire logic cpuMask,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic irq
);
  logic taken;
  assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_bus_answer: assert property (taken |=> wb_ack_o ^ wb_err_o)
    else $error("request not answered next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_unmapped_err: assert property (taken && wb_adr_i[4:2] == 3'h7 |=> wb_err_o && !wb_ack_o)
    else $error("unmapped address not refused");
  a_mapped_ack: assert property (taken && wb_adr_i[4:2] != 3'h7 |=> wb_ack_o && !wb_err_o)
    else $error("mapped address not acknowledged");
  a_idle_quiet: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
    else $error("answer without request");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_flag_top: assert property (taken && !wb_we_i && wb_adr_i[4:2] == 3'h0 |=>
    wb_dat_o[7:6] == 2'b00) else $error("unused flag bits set");
  a_irq_masked: assert property (cpuMask && $past(cpuMask) |-> !irq)
    else $error("irq while masked");
  a_reset_quiet: assert property ($fell(rst) |-> !irq && !wb_ack_o && !wb_err_o)
    else $error("outputs active after reset");
endmodule // serial_rx_props
bind serial_rx serial_rx_props serial_rx_props_i (.clk(clk), .rst(rst),
  .serialInPin(serialInPin), .cpuMask(cpuMask), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .irq(irq));
`default_nettype wire

// *** bench/serial_line_model.sv ***
// serial_line_model.sv: far-side equipment sending frames on the line
// assumes the caller gives the bit length in clk cycles
`default_nettype none
module serial_line_model (
  input wire logic clk,
  output var logic lineOut
);
  timeunit 1ns;
  timeprecision 1ns;
  initial lineOut = 1'b1;
  // start, data lsb first, stop; line idles high
  task automatic send(input logic [8:0] w, input int n, input logic stopV, input int bitClks);
    int k;
    @(posedge clk);
    lineOut <= 1'b0;
    repeat (bitClks) @(posedge clk);
    for (k = 0; k < n; k++) begin
      lineOut <= w[k];
      repeat (bitClks) @(posedge clk);
    end
    lineOut <= stopV;
    repeat (bitClks) @(posedge clk);
    lineOut <= 1'b1;
  endtask
endmodule // serial_line_model
`default_nettype wire

// *** bench/async_serial_receiver_bench.sv ***
// async_serial_receiver_bench.sv: self-checking bench for serial_rx
// assumes serial_line_model drives the serial input
`default_nettype none
module async_serial_receiver_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, serialInPin, cpuMask, cyc, stb, we, ack, err, irq, e;
  logic [4:0] adr;
  logic [31:0] datI, datO;
  logic [3:0] sel;
  logic [7:0] q, d;
  logic [8:0] w;
  logic [7:0] expQ[$];
  int failures, checks, cycles, seed, bitClks, i;

  serial_rx serial_rx_i (.clk(clk), .rst(rst), .serialInPin(serialInPin), .cpuMask(cpuMask),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(datI),
    .wb_sel_i(sel), .wb_dat_o(datO), .wb_ack_o(ack), .wb_err_o(err), .irq(irq));
  serial_line_model serial_line_model_i (.clk(clk), .lineOut(serialInPin));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wb(input logic wr, input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    datI <= {24'h0, v};
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
    q = datO[7:0];
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rdChk(input logic [4:0] a, input logic [7:0] x, input string what);
    wb(1'b0, a, 8'h00);
    check(what, q, x);
  endtask

  task automatic rx(input logic [8:0] v, input int n, input logic stopV);
    serial_line_model_i.send(v, n, stopV, bitClks);
    repeat (bitClks * 2) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    cpuMask = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 5'h00;
    datI = 32'h0;
    sel = 4'h0;
    failures = 0;
    checks = 0;
    cycles = 0;
    seed = 32'h6012;
    bitClks = 32;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i++) rdChk(5'(i * 4), 8'h00, "reset value");
    wb(1'b1, 5'h00, 8'hff);
    rdChk(5'h00, 8'h00, "flag write ignored");
    wb(1'b0, 5'h1c, 8'h00);
    check("unmapped err", e, 1'b1);
    $display("test registers done");
    wb(1'b1, 5'h08, 8'h01);
    wb(1'b1, 5'h10, 8'h24);
    d = 8'($random(seed)) & 8'h7e;
    expQ.push_back(d);
    rx({1'b0, d}, 8, 1'b1);
    check("irq masked", irq, 1'b0);
    cpuMask <= 1'b0;
    repeat (2) @(posedge clk);
    check("irq", irq, 1'b1);
    rdChk(5'h04, expQ[0], "data early");
    rdChk(5'h00, 8'h20, "full kept");
    d = 8'($random(seed)) & 8'h7e;
    rx({1'b0, d}, 8, 1'b1);
    rdChk(5'h00, 8'h28, "overrun");
    rdChk(5'h04, expQ.pop_front(), "buffer kept");
    rdChk(5'h00, 8'h00, "cleared");
    check("irq off", irq, 1'b0);
    d = 8'($random(seed)) & 8'h7e;
    expQ.push_back(d);
    rx({1'b0, d}, 8, 1'b0);
    rdChk(5'h00, 8'h22, "framing");
    rdChk(5'h04, expQ.pop_front(), "framing data");
    $display("test receive done");
    wb(1'b1, 5'h10, 8'h04);
    for (i = 0; i < 4; i++) begin
      wb(1'b1, 5'h0c, {5'h00, 1'b1, i[0], 1'b1});
      d = 8'($random(seed)) & 8'h3e;
      w = {1'b0, ^d[6:0] ^ i[0] ^ i[1], d[6:0]};
      expQ.push_back(w[7:0]);
      rx(w, 8, 1'b1);
      check("parity irq", irq, i[1]);
      rdChk(5'h00, {7'h10, i[1]}, "parity flag");
      rdChk(5'h04, expQ.pop_front(), "parity data");
    end
    $display("test parity done");
    wb(1'b1, 5'h0c, 8'h10);
    w = {1'b1, 8'($random(seed)) & 8'h7e};
    rx(w, 9, 1'b1);
    rdChk(5'h0c, 8'h90, "ninth bit");
    rdChk(5'h00, 8'h20, "nine full");
    rdChk(5'h04, w[7:0], "nine data");
    $display("test nine bits done");
    wb(1'b1, 5'h0c, 8'h08);
    wb(1'b1, 5'h10, 8'h06);
    rx({1'b0, 8'h35}, 8, 1'b1);
    rdChk(5'h00, 8'h00, "muted");
    rx({1'b0, 8'hb5}, 8, 1'b1);
    rdChk(5'h10, 8'h04, "woken");
    rdChk(5'h00, 8'h20, "wake full");
    rdChk(5'h04, 8'hb5, "wake data");
    $display("test mute done");
    wb(1'b1, 5'h10, 8'h00);
    wb(1'b1, 5'h0c, 8'h00);
    wb(1'b1, 5'h08, 8'h00);
    wb(1'b1, 5'h14, 8'h03);
    bitClks = 48;
    wb(1'b1, 5'h10, 8'h04);
    rdChk(5'h14, 8'h03, "fine value");
    d = 8'($random(seed)) & 8'h7e;
    rx({1'b0, d}, 8, 1'b1);
    rdChk(5'h00, 8'h20, "fine full");
    rdChk(5'h04, d, "fine data");
    repeat (bitClks * 12) @(posedge clk);
    rdChk(5'h00, 8'h10, "idle flag");
    $display("test fine prescaler done");
    complete_run();
  end
endmodule // async_serial_receiver_bench
`default_nettype wire
